// ===== output_function_selector_pkg.sv
package output_function_selector_pkg;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [11:0] ADDR_LOAD_SEL = 12'h000;
  localparam logic [11:0] ADDR_AUX_SEL = 12'h004;
  localparam logic [11:0] ADDR_EXT_SEL = 12'h008;
  localparam logic [11:0] ADDR_CONTROL = 12'h00C;
  localparam logic [11:0] ADDR_STATUS = 12'h010;

  // ----------------------------------------
  // Field layout and reset values
  // ----------------------------------------
  localparam int SEL_W = 4;
  localparam int EXT_SEL_W = 3;
  localparam int EXT_COUNT = 3;
  localparam int EXT_FIELD_STRIDE = 4;
  localparam int CTRL_PWM_LOAD_BIT = 0;
  localparam logic [SEL_W-1:0] LOAD_SEL_RESET = 4'h1;
  localparam logic [SEL_W-1:0] AUX_SEL_RESET = 4'h2;
  localparam logic [EXT_SEL_W-1:0] EXT_SEL_RESET = 3'h0;
  localparam logic [SEL_W-1:0] SEL_MAX = 4'hB;
  localparam logic [SEL_W-1:0] SEL_SHUNT = 4'hA;
  localparam logic [SEL_W-1:0] SEL_SHUNT_INV = 4'hB;

  // ----------------------------------------
  // Status bit positions
  // ----------------------------------------
  localparam int STAT_LOAD_BIT = 0;
  localparam int STAT_AUX_BIT = 1;
  localparam int STAT_EXT_LSB = 2;
  localparam int STAT_MENU_LSB = 5;
  localparam int STAT_PWM_BLOCK_BIT = 7;

  // ----------------------------------------
  // Internal function indices (code >> 1)
  // ----------------------------------------
  typedef enum logic [2:0] {
    FN_LOW_BATT = 3'h0,
    FN_GENERATOR = 3'h1,
    FN_EVENT = 3'h2,
    FN_SECOND_BATT = 3'h3,
    FN_ALARM = 3'h4,
    FN_SHUNT = 3'h5
  } func_t;

  // Menu states, Gray coded along the walk
  typedef enum logic [1:0] {
    MENU_TOP = 2'b00,
    MENU_SW_A = 2'b01,
    MENU_SW_B = 2'b11,
    MENU_SW_C = 2'b10
  } menu_t;

endpackage : output_function_selector_pkg

// ===== output_function_selector.sv
`timescale 1ns/1ns
// Notes on behaviour
// RULE1: Load switch follows one of twelve codes choosing function and on/off sense.
// RULE2: Codes 0 and 1 follow low battery disconnect, on and off respectively.
// RULE3: Load selection resets to code 1.
// RULE4: Codes 2 and 3 follow generator run, on and off respectively.
// RULE5: Codes 4 and 5 follow the event controller, on and off.
// RULE6: Codes 6 and 7 follow second battery charge, on and off.
// RULE7: Code 8 turns load on while battery is below alarm level.
// RULE8: Code 9 turns load off while battery is below alarm level.
// RULE9: Code 10 follows shunt, on for regulation; only code allowing load PWM.
// RULE10: Code 11 follows shunt inverted, on when shunt load disconnect wanted.
// RULE11: Inverted shunt must not be combined with load PWM.
// RULE12: Aux relay uses the same twelve codes but never carries PWM.
// RULE13: Series and shunt control may run together; shunt on either terminal.
// RULE14: Each external switch block has its own selection, blocks A to C.
// RULE15: External selection 0 on when charging wanted, 1 off.
// RULE16: External selection 2 on while load should be off, 3 off.
// RULE17: External selection 4 on below alarm level, 5 off.
// RULE18: External selection 6 on while event active, 7 off.
// RULE19: Long press shows first switch, short presses advance, top after third.
// RULE20: Each drive is function flag XOR code low bit, registered; load at code 10 with PWM enabled is the flag ANDed with the PWM wave.
module output_function_selector
  import output_function_selector_pkg::*;
(
  input wire logic pclk, // System clock
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic low_batt_disconnect, // Low battery disconnect wanted
  input wire logic generator_run, // Generator run wanted
  input wire logic event_active, // Event controller active
  input wire logic second_batt_charge, // Second battery should charge
  input wire logic below_alarm, // Battery below alarm threshold
  input wire logic shunt_disconnect, // Shunt wants dump load disconnected
  input wire logic charge_wanted, // Series charge wanted
  input wire logic pwm_wave, // Shunt PWM waveform
  input wire logic button_long, // Menu button long press (pin)
  input wire logic button_short, // Menu button short press (pin)
  output logic load_drive, // LOAD switch drive
  output logic aux_drive, // Aux relay drive
  output logic [EXT_COUNT-1:0] ext_drive, // External switch drives
  output logic [1:0] menu_position // External switch menu position
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [9:0] sync_a;
  logic [9:0] sync_b;
  logic btn_long_q;
  logic btn_short_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= 10'h000;
      sync_b <= 10'h000;
    end else begin
      sync_a <= {button_short, button_long, pwm_wave, charge_wanted, shunt_disconnect,
                 below_alarm, second_batt_charge, event_active, generator_run, low_batt_disconnect};
      sync_b <= sync_a;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      btn_long_q <= 1'b0;
      btn_short_q <= 1'b0;
    end else begin
      btn_long_q <= sync_b[8];
      btn_short_q <= sync_b[9];
    end
  end

  logic [5:0] func_flags;
  logic s_charge;
  logic s_pwm;
  logic long_rise;
  logic short_rise;
  assign func_flags = sync_b[5:0];
  assign s_charge = sync_b[6];
  assign s_pwm = sync_b[7];
  assign long_rise = sync_b[8] & ~btn_long_q;
  assign short_rise = sync_b[9] & ~btn_short_q;

  // Shunt flag means disconnect wanted, so the even shunt code drives on during regulation
  logic [5:0] on_flags;
  assign on_flags = {~func_flags[FN_SHUNT], func_flags[FN_ALARM:FN_LOW_BATT]};

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [SEL_W-1:0] load_output_select;
  logic [SEL_W-1:0] aux_relay_select;
  logic [EXT_SEL_W-1:0] ext_switch_select [EXT_COUNT];
  logic pwm_load_en;
  logic wr_en;
  logic rd_en;
  logic addr_ok;

  assign wr_en = psel & penable & pwrite & pready;
  assign rd_en = psel & penable & ~pwrite;
  assign addr_ok = (paddr == ADDR_LOAD_SEL) || (paddr == ADDR_AUX_SEL) || (paddr == ADDR_EXT_SEL)
                   || (paddr == ADDR_CONTROL) || (paddr == ADDR_STATUS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_output_select <= LOAD_SEL_RESET; // RULE3
    end else if (wr_en && paddr == ADDR_LOAD_SEL && pwdata[SEL_W-1:0] <= SEL_MAX) begin
      load_output_select <= pwdata[SEL_W-1:0]; // RULE1
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_relay_select <= AUX_SEL_RESET;
    end else if (wr_en && paddr == ADDR_AUX_SEL && pwdata[SEL_W-1:0] <= SEL_MAX) begin
      aux_relay_select <= pwdata[SEL_W-1:0]; // RULE12
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_load_en <= 1'b0;
    end else if (wr_en && paddr == ADDR_CONTROL) begin
      pwm_load_en <= pwdata[CTRL_PWM_LOAD_BIT];
    end
  end

  // ----------------------------------------
  // Load and aux terminal drive
  // ----------------------------------------
  logic load_active;
  logic aux_active;
  logic pwm_on_load;
  logic next_load;
  logic next_aux;

  assign load_active = (load_output_select <= SEL_MAX) ? on_flags[load_output_select[3:1]] : 1'b0; // RULE2 RULE4 RULE5 RULE6
  assign aux_active = (aux_relay_select <= SEL_MAX) ? on_flags[aux_relay_select[3:1]] : 1'b0; // RULE13
  assign pwm_on_load = pwm_load_en && load_output_select == SEL_SHUNT; // RULE9 RULE11

  always_comb begin
    if (pwm_on_load) begin
      next_load = on_flags[FN_SHUNT] & s_pwm; // RULE9
    end else begin
      next_load = load_active ^ load_output_select[0]; // RULE20 RULE7 RULE8 RULE10
    end
  end

  // Aux never gets the PWM waveform
  assign next_aux = aux_active ^ aux_relay_select[0]; // RULE12

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_drive <= 1'b0;
      aux_drive <= 1'b0;
    end else begin
      load_drive <= next_load; // RULE20
      aux_drive <= next_aux;
    end
  end

  // ----------------------------------------
  // External switch blocks
  // ----------------------------------------
  logic [3:0] ext_flags;
  assign ext_flags = {func_flags[FN_EVENT], func_flags[FN_ALARM], func_flags[FN_LOW_BATT], s_charge};

  genvar gi;
  generate
    for (gi = 0; gi < EXT_COUNT; gi++) begin : g_ext
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ext_switch_select[gi] <= EXT_SEL_RESET;
        end else if (wr_en && paddr == ADDR_EXT_SEL) begin
          ext_switch_select[gi] <= pwdata[gi*EXT_FIELD_STRIDE +: EXT_SEL_W]; // RULE14
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ext_drive[gi] <= 1'b0;
        end else begin
          ext_drive[gi] <= ext_flags[ext_switch_select[gi][2:1]] ^ ext_switch_select[gi][0]; // RULE15 RULE16 RULE17 RULE18
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // External switch menu walk
  // ----------------------------------------
  menu_t menu_state;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      menu_state <= MENU_TOP;
    end else begin
      case (menu_state)
        MENU_TOP: begin
          if (long_rise) begin
            menu_state <= MENU_SW_A; // RULE19
          end
        end
        MENU_SW_A: begin
          if (short_rise) begin
            menu_state <= MENU_SW_B;
          end
        end
        MENU_SW_B: begin
          if (short_rise) begin
            menu_state <= MENU_SW_C;
          end
        end
        MENU_SW_C: begin
          if (short_rise) begin
            menu_state <= MENU_TOP; // RULE19
          end
        end
        default: begin
          menu_state <= MENU_TOP;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      menu_position <= 2'h0;
    end else begin
      menu_position <= menu_state;
    end
  end

  // ----------------------------------------
  // APB read and answer
  // ----------------------------------------
  logic [31:0] next_rdata;
  logic [31:0] ext_word;

  always_comb begin
    ext_word = 32'h0000_0000;
    for (int i = 0; i < EXT_COUNT; i++) begin
      ext_word[i*EXT_FIELD_STRIDE +: EXT_SEL_W] = ext_switch_select[i];
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (paddr == ADDR_LOAD_SEL) begin
      next_rdata[SEL_W-1:0] = load_output_select;
    end else if (paddr == ADDR_AUX_SEL) begin
      next_rdata[SEL_W-1:0] = aux_relay_select;
    end else if (paddr == ADDR_EXT_SEL) begin
      next_rdata = ext_word;
    end else if (paddr == ADDR_CONTROL) begin
      next_rdata[CTRL_PWM_LOAD_BIT] = pwm_load_en;
    end else if (paddr == ADDR_STATUS) begin
      next_rdata[STAT_LOAD_BIT] = load_drive;
      next_rdata[STAT_AUX_BIT] = aux_drive;
      next_rdata[STAT_EXT_LSB +: EXT_COUNT] = ext_drive;
      next_rdata[STAT_MENU_LSB +: 2] = menu_position;
      next_rdata[STAT_PWM_BLOCK_BIT] = pwm_load_en && load_output_select == SEL_SHUNT_INV; // RULE11
    end
  end

  // One wait state: ready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~addr_ok;
      prdata <= (rd_en & ~pready) ? next_rdata : 32'h0000_0000;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property drive_follows(logic match, logic flag, logic inv, logic drv);
    @(posedge pclk) disable iff (!presetn)
      match |=> drv == ($past(flag) ^ inv);
  endproperty

  // Load and aux polarity per code
  load_polarity_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE20
    load_output_select < SEL_SHUNT |=>
      load_drive == ($past(func_flags[load_output_select[3:1]]) ^ $past(load_output_select[0])))
    else $error("load drive wrong");
  aux_never_pwm_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
    aux_relay_select == SEL_SHUNT |=> aux_drive == !$past(func_flags[FN_SHUNT]))
    else $error("aux drive wrong");
  alarm_on_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    load_output_select == 4'h8 && func_flags[FN_ALARM] && !pwm_on_load |=> load_drive)
    else $error("alarm on");
  alarm_off_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    load_output_select == 4'h9 && func_flags[FN_ALARM] |=> !load_drive)
    else $error("alarm off");
  shunt_inv_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
    load_output_select == SEL_SHUNT_INV && func_flags[FN_SHUNT] |=> load_drive)
    else $error("inv shunt");
  pwm_only_shunt_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
    load_output_select == SEL_SHUNT && pwm_load_en && !s_pwm |=> !load_drive)
    else $error("pwm gate on shunt");
  load_reset_a: assert property (@(posedge pclk) // RULE3
    $rose(presetn) |-> load_output_select == 4'h1)
    else $error("load reset code");
  low_batt_on_a: assert property ( // RULE2
    drive_follows(load_output_select == 4'h0, func_flags[FN_LOW_BATT], 1'b0, load_drive))
    else $error("low batt on");
  gen_off_a: assert property ( // RULE4
    drive_follows(load_output_select == 4'h3, func_flags[FN_GENERATOR], 1'b1, load_drive))
    else $error("generator off");
  event_on_a: assert property ( // RULE5
    drive_follows(aux_relay_select == 4'h4, func_flags[FN_EVENT], 1'b0, aux_drive))
    else $error("event on");
  batt2_off_a: assert property ( // RULE6
    drive_follows(load_output_select == 4'h7, func_flags[FN_SECOND_BATT], 1'b1, load_drive))
    else $error("second battery off");
  aux_shunt_inv_a: assert property ( // RULE13
    drive_follows(aux_relay_select == SEL_SHUNT_INV, func_flags[FN_SHUNT], 1'b0, aux_drive))
    else $error("aux inv shunt");
  inv_shunt_plain_a: assert property ( // RULE11
    drive_follows(pwm_load_en && load_output_select == SEL_SHUNT_INV, func_flags[FN_SHUNT], 1'b0, load_drive))
    else $error("inv shunt got pwm");

  // External switch polarity per selection
  ext_charge_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
    ext_switch_select[0] == 3'h0 && s_charge |=> ext_drive[0])
    else $error("ext charge");
  ext_event_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE18
    ext_switch_select[1] == 3'h7 && func_flags[FN_EVENT] |=> !ext_drive[1])
    else $error("ext event");
  ext_charge_off_a: assert property ( // RULE15
    drive_follows(ext_switch_select[1] == 3'h1, s_charge, 1'b1, ext_drive[1]))
    else $error("ext charge off");
  ext_load_off_a: assert property ( // RULE16
    drive_follows(ext_switch_select[2] == 3'h2, func_flags[FN_LOW_BATT], 1'b0, ext_drive[2]))
    else $error("ext load off");
  ext_alarm_a: assert property ( // RULE17
    drive_follows(ext_switch_select[0] == 3'h5, func_flags[FN_ALARM], 1'b1, ext_drive[0]))
    else $error("ext alarm");

  // Bus answer shape
  ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held");
  slverr_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error without ready");

  sequence walk_to_c;
    menu_state == MENU_SW_C && short_rise;
  endsequence
  menu_wrap_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE19
    walk_to_c |=> menu_state == MENU_TOP ##1 menu_position == MENU_TOP)
    else $error("menu wrap");
  menu_enter_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE19
    menu_state == MENU_TOP && long_rise |=> menu_state == MENU_SW_A)
    else $error("menu enter");
  sequence step_from_a;
    menu_state == MENU_SW_A && short_rise;
  endsequence
  menu_step_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE19
    step_from_a |=> menu_state == MENU_SW_B)
    else $error("menu step");

endmodule : output_function_selector

// ===== switch_bank_model.sv
`timescale 1ns/1ns
module switch_bank_model
  import output_function_selector_pkg::*;
(
  input wire logic load_drive, // LOAD switch drive
  input wire logic aux_drive, // Aux relay drive
  input wire logic [EXT_COUNT-1:0] ext_drive, // External switch drives
  output logic [EXT_COUNT+1:0] closed // Contacts closed: ext, aux, load
);
  // ----------------------------------------
  // Contacts follow their coils
  // ----------------------------------------
  assign closed = {ext_drive, aux_drive, load_drive};
endmodule : switch_bank_model

// ===== output_function_selector_tb_top.sv
`timescale 1ns/1ns
module output_function_selector_tb_top
  import output_function_selector_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic load_drive;
  logic aux_drive;
  logic [EXT_COUNT-1:0] ext_drive;
  logic [1:0] menu_position;
  logic [7:0] fl = 8'h00;
  logic b_long = 1'b0;
  logic b_short = 1'b0;
  logic [4:0] closed;
  logic [31:0] rd;
  logic er;
  logic [31:0] rs = 32'h0000F401;
  logic [1:0] menu = 2'b00;
  int n_errors = 0;
  int tests_run = 0;
  int lsel = 1;
  int asel = 2;
  int pwm_en = 0;
  int esel[3] = '{0, 0, 0};
  int emap[4] = '{6, 0, 4, 2};

  always #4 pclk = ~pclk;

  output_function_selector i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .low_batt_disconnect(fl[0]), .generator_run(fl[1]), .event_active(fl[2]), .second_batt_charge(fl[3]),
    .below_alarm(fl[4]), .shunt_disconnect(fl[5]), .charge_wanted(fl[6]), .pwm_wave(fl[7]),
    .button_long(b_long), .button_short(b_short), .load_drive(load_drive), .aux_drive(aux_drive),
    .ext_drive(ext_drive), .menu_position(menu_position));

  switch_bank_model i_far (.load_drive(load_drive), .aux_drive(aux_drive), .ext_drive(ext_drive),
    .closed(closed));

  // ----------------------------------------
  // Reference model
  // ----------------------------------------
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : xs

  function automatic logic term(input int c, input bit ld);
    logic f;
    f = (c / 2 == 5) ? !fl[5] : fl[c / 2];
    f = f ^ 1'(c % 2);
    if (ld && c == 10 && pwm_en == 1) f = f & fl[7];
    return f;
  endfunction : term

  function automatic logic [4:0] exp_all();
    logic [2:0] e;
    foreach (esel[i]) e[i] = fl[emap[esel[i] / 2]] ^ 1'(esel[i] % 2);
    return {e, term(asel, 0), term(lsel, 1)};
  endfunction : exp_all

  // ----------------------------------------
  // Bus, stimulus and compare tasks
  // ----------------------------------------
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t register got %h expected %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_drive(input logic [4:0] got, input logic [4:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t drives got %b expected %b", $time, got, exp);
    end
  endtask : chk_drive

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic flags(input logic [7:0] v);
    @(posedge pclk);
    fl <= v;
    repeat (4) @(posedge pclk);
  endtask : flags

  task automatic complete_run();
    if (n_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  initial begin
    #200000;
    n_errors++;
    complete_run();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] r;
    logic [31:0] w;
    bit seq[6] = '{0, 1, 1, 0, 0, 0};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_LOAD_SEL, 32'h0);
    chk_reg(rd, 32'h1);
    apb(1'b0, ADDR_AUX_SEL, 32'h0);
    chk_reg(rd, 32'h2);
    apb(1'b0, ADDR_EXT_SEL, 32'h0);
    chk_reg(rd, 32'h0);
    apb(1'b1, 12'h014, 32'h1);
    chk_reg({31'h0, er}, 32'h1);
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, ADDR_CONTROL, 32'(p));
      pwm_en = p;
      for (int c = 0; c < 16; c++) begin
        apb(1'b1, ADDR_LOAD_SEL, 32'(c));
        apb(1'b1, ADDR_AUX_SEL, 32'(15 - c));
        if (c <= 11) lsel = c;
        if (15 - c <= 11) asel = 15 - c;
        apb(1'b0, ADDR_LOAD_SEL, 32'h0);
        chk_reg(rd, 32'(lsel));
        repeat (2) begin
          r = xs();
          flags(r[7:0]);
          chk_drive(closed, exp_all());
          flags(~r[7:0]);
          chk_drive(closed, exp_all());
        end
      end
    end
    for (int c = 0; c < 8; c++) begin
      foreach (esel[i]) esel[i] = (c + 3 * i) % 8;
      w = {21'h0, 3'(esel[2]), 1'b0, 3'(esel[1]), 1'b0, 3'(esel[0])};
      apb(1'b1, ADDR_EXT_SEL, w);
      apb(1'b0, ADDR_EXT_SEL, 32'h0);
      chk_reg(rd, w);
      r = xs();
      flags(r[7:0]);
      chk_drive(closed, exp_all());
      flags(~r[7:0]);
      chk_drive(closed, exp_all());
    end
    foreach (seq[i]) begin
      @(posedge pclk);
      if (seq[i]) b_long <= 1'b1;
      else b_short <= 1'b1;
      repeat (4) @(posedge pclk);
      b_long <= 1'b0;
      b_short <= 1'b0;
      repeat (4) @(posedge pclk);
      if (seq[i] && menu == 2'b00) menu = 2'b01;
      else if (!seq[i]) menu = (menu == 2'b01) ? 2'b11 : (menu == 2'b11) ? 2'b10 : 2'b00;
      chk_reg({30'h0, menu_position}, {30'h0, menu});
    end
    for (int p = 1; p >= 0; p--) begin
      apb(1'b1, ADDR_CONTROL, 32'(p));
      pwm_en = p;
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk_reg(rd, {24'h0, 1'(p), menu, exp_all()});
    end
    complete_run();
  end
endmodule : output_function_selector_tb_top
